// file: core/shsrp_pkg.sv
// shsrp_pkg: register map, field positions, timing and state codes
// for the stepper home-seek and rate-profile block.
// assumes a 100 MHz system clock and 32-bit Avalon-MM register access.
package shsrp_pkg;

	// clock and step pulse timing
	localparam int CLK_HZ = 100_000_000;
	localparam int STEP_PULSE_NS = 1000;
	localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	// rate table and profile
	localparam int RATE_ENTRIES = 256;
	localparam int HOME_RATE_DIV = 20;
	localparam int DISP_CHARS = 11;

	// register byte offsets
	localparam logic [11:0] REG_MODE = 12'h000;
	localparam logic [11:0] REG_START_RATE = 12'h004;
	localparam logic [11:0] REG_SLEW_RATE = 12'h008;
	localparam logic [11:0] REG_SLOPE = 12'h00C;
	localparam logic [11:0] REG_STEPS = 12'h010;
	localparam logic [11:0] REG_HOME_ARG = 12'h014;
	localparam logic [11:0] REG_COMMAND = 12'h018;
	localparam logic [11:0] REG_STATUS = 12'h01C;
	localparam logic [11:0] REG_POSITION = 12'h020;
	localparam logic [11:0] REG_TABLE_BASE = 12'h400;

	// field positions
	localparam int MODE_DISP_BIT = 4;
	localparam int CMD_MOVE_BIT = 0;
	localparam int CMD_HOME_BIT = 1;
	localparam int CMD_CCW_BIT = 8;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_HOMED_BIT = 1;
	localparam int ST_ABORT_BIT = 2;
	localparam int ST_SLEW_BIT = 3;
	localparam int ST_HOMING_BIT = 4;
	localparam int ST_IDX_LSB = 8;

	// home argument decoding
	localparam int HARG_GROUP_BIT = 6;
	localparam int HARG_LOW_BIT = 4;
	localparam int HARG_DATA_BIT = 3;

	// reset values
	localparam logic [7:0] SLOPE_RST = 8'h01;
	localparam logic [7:0] SLOPE_MIN = 8'h01;
	localparam logic [15:0] TABLE_RST = 16'hFFFF;

	// ascii characters used in the position string
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_LF = 8'h0A;

	typedef enum logic [2:0] {
		SH_IDLE = 3'b000,
		SH_STEP = 3'b001,
		SH_DISP = 3'b010,
		SH_NEXT = 3'b011
	} shsrp_state_t;

endpackage

// file: core/shsrp_top.sv
// shsrp_top: stepper home seek and step-rate profile generator with an
// Avalon-MM register slave and a byte-wide position display port.
// assumes limit and sensor pins are asynchronous; display sink is on clk.
//
// Contract
// - mode bit 4 set: position is sent to display after each home step.
// - sending the 11-character position string lengthens the step period.
// - home argument picks one user or data bit, or user bits 0-5 group.
// - home seek steps at start-rate period times 20, no ramp.
// - home start: if pattern matches, step ccw until no longer matching.
// - no initial match: skip ccw phase, go straight to cw seeking.
// - step cw while no match; first matching step stops and zeroes position.
// - limit during home aborts seek, stops, position left unchanged.
// - each rate parameter indexes a 256-entry step-rate table.
// - start rate from start index, slew rate from slew index.
// - table holds periods in clock cycles, so rates scale with clock.
// - moves ramp up from start to slew, slew, then ramp back down.
// - short moves accelerate only as far as possible, then decelerate.
// - slope 1 to 255 sets index advance speed, 1 slowest.
// - ramp shape depends on slope only; start and slew set its ends.
// - limit low in move direction stops at once; low at start: no step.
// - direction output low for clockwise, high for counter-clockwise.
`timescale 1ns/1ps
module shsrp_top
	import shsrp_pkg::*;
#(
	parameter int PULSE_CYC = STEP_PULSE_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// avalon-mm register slave
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// motor driver
	output logic step_pulse,
	output logic rotation_direction,
	// limits and sensors, asynchronous pins
	input wire logic clockwise_stop_input,
	input wire logic counterclockwise_stop_input,
	input wire logic [7:0] user_bits,
	input wire logic [7:0] data_bits,
	// position display sink
	output logic [7:0] disp_data,
	output logic disp_valid,
	input wire logic disp_ready,
	// status
	output logic busy
);
	import shsrp_pkg::*;

	shsrp_state_t state_q;
	logic [31:0] readdata_q;
	logic wait_q;
	logic [4:0] mode_q;
	logic [7:0] start_idx_q, slew_idx_q, slope_q, home_arg_q;
	logic [31:0] steps_q;
	logic cmd_move_q, cmd_home_q, cmd_ccw_q;
	logic [15:0] rate_mem [RATE_ENTRIES];
	logic [1:0] cw_lim_s, ccw_lim_s;
	logic [7:0] user_s1, user_s2, data_s1, data_s2;
	logic homing_q, ccw_phase_q, dir_q, homed_q, abort_q;
	logic [7:0] idx_q, acc_q;
	logic [31:0] rem_q, up_steps_q;
	logic [23:0] period_q, elap_q;
	logic pulse_q;
	logic [31:0] pos_q;
	logic [3:0] char_q;
	logic [7:0] disp_data_q;
	logic disp_valid_q;
	logic [11:0] word_addr;
	logic access, match, lim_hit, start_lim, step_start, home_hit;
	logic [7:0] top_idx;
	logic [8:0] acc_sum;
	logic [23:0] run_period, home_period;

	// two-flop synchronisers for every limit and sensor pin
	always_ff @(posedge clk) begin
		cw_lim_s <= {cw_lim_s[0], clockwise_stop_input};
		ccw_lim_s <= {ccw_lim_s[0], counterclockwise_stop_input};
		user_s1 <= user_bits;
		user_s2 <= user_s1;
		data_s1 <= data_bits;
		data_s2 <= data_s1;
	end

	always_comb begin
		if (home_arg_q[HARG_GROUP_BIT]) begin
			match = (user_s2[5:0] == home_arg_q[5:0]);
		end else begin
			match = (home_arg_q[HARG_DATA_BIT] ? data_s2[home_arg_q[2:0]] : user_s2[home_arg_q[2:0]])
				^ home_arg_q[HARG_LOW_BIT];
		end
	end

	// limits are active low; only the one facing the travel matters
	// direction-specific limit
	assign lim_hit = dir_q ? !ccw_lim_s[1] : !cw_lim_s[1];

	// limit for the direction a new command would start in
	always_comb begin
		if (cmd_home_q) begin
			start_lim = match ? !ccw_lim_s[1] : !cw_lim_s[1];
		end else begin
			start_lim = cmd_ccw_q ? !ccw_lim_s[1] : !cw_lim_s[1];
		end
	end

	// ramp ends; a slew index below the start index means no ramp
	assign top_idx = (slew_idx_q > start_idx_q) ? slew_idx_q : start_idx_q;
	// slope accumulates; each carry moves the index one entry
	assign acc_sum = {1'b0, acc_q} + {1'b0, slope_q};

	// period straight from the table, in clock cycles
	assign run_period = {8'h00, rate_mem[idx_q]};
	// home period is the start-rate period times twenty
	assign home_period = 24'(rate_mem[start_idx_q]) * 24'(HOME_RATE_DIV);

	assign step_start = (state_q == SH_STEP) && (elap_q == 24'h000000);
	// first cw step that matches ends the seek
	assign home_hit = (state_q == SH_NEXT) && homing_q && !ccw_phase_q && match;

	// bus decode helpers
	assign word_addr = {avs_address[11:2], 2'b00};
	assign access = (avs_read || avs_write) && wait_q;

	// waitrequest: high idle, low for one cycle to complete each access
	always_ff @(posedge clk) begin
		if (rst) begin
			wait_q <= 1'b1;
		end else if (access) begin
			wait_q <= 1'b0;
		end else begin
			wait_q <= 1'b1;
		end
	end

	// read data captured on the same edge that drops waitrequest
	always_ff @(posedge clk) begin
		if (rst) begin
			readdata_q <= 32'h00000000;
		end else if (access && avs_read) begin
			if (word_addr >= REG_TABLE_BASE) begin
				readdata_q <= {16'h0000, rate_mem[avs_address[9:2]]};
			end else if (word_addr == REG_MODE) begin
				readdata_q <= {27'h0000000, mode_q};
			end else if (word_addr == REG_START_RATE) begin
				readdata_q <= {24'h000000, start_idx_q};
			end else if (word_addr == REG_SLEW_RATE) begin
				readdata_q <= {24'h000000, slew_idx_q};
			end else if (word_addr == REG_SLOPE) begin
				readdata_q <= {24'h000000, slope_q};
			end else if (word_addr == REG_STEPS) begin
				readdata_q <= steps_q;
			end else if (word_addr == REG_HOME_ARG) begin
				readdata_q <= {24'h000000, home_arg_q};
			end else if (word_addr == REG_STATUS) begin
				readdata_q <= {16'h0000, idx_q, 3'b000, homing_q,
					(idx_q == top_idx) && (state_q != SH_IDLE) && !homing_q, abort_q, homed_q,
					state_q != SH_IDLE};
			end else if (word_addr == REG_POSITION) begin
				readdata_q <= pos_q;
			end else begin
				readdata_q <= 32'h00000000;
			end
		end
	end

	// parameter registers, written on the completing edge
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_q <= 5'h00;
			start_idx_q <= 8'h00;
			slew_idx_q <= 8'h00;
			slope_q <= SLOPE_RST;
			steps_q <= 32'h00000000;
			home_arg_q <= 8'h00;
		end else if (avs_write && !wait_q) begin
			if (word_addr == REG_MODE) begin
				mode_q <= avs_writedata[4:0];
			end else if (word_addr == REG_START_RATE) begin
				start_idx_q <= avs_writedata[7:0];
			end else if (word_addr == REG_SLEW_RATE) begin
				slew_idx_q <= avs_writedata[7:0];
			end else if (word_addr == REG_SLOPE) begin
				// zero is outside the range, treated as slowest
				slope_q <= (avs_writedata[7:0] < SLOPE_MIN) ? SLOPE_MIN : avs_writedata[7:0];
			end else if (word_addr == REG_STEPS) begin
				steps_q <= avs_writedata;
			end else if (word_addr == REG_HOME_ARG) begin
				home_arg_q <= avs_writedata[7:0];
			end
		end
	end

	// rate table; no reset, software loads it before use
	always_ff @(posedge clk) begin
		if (avs_write && !wait_q && word_addr >= REG_TABLE_BASE) begin
			rate_mem[avs_address[9:2]] <= avs_writedata[15:0];
		end
	end

	// command strobes; ignored while a motion runs
	always_ff @(posedge clk) begin
		if (rst) begin
			cmd_move_q <= 1'b0;
			cmd_home_q <= 1'b0;
			cmd_ccw_q <= 1'b0;
		end else begin
			cmd_move_q <= avs_write && !wait_q && word_addr == REG_COMMAND && state_q == SH_IDLE
				&& avs_writedata[CMD_MOVE_BIT] && !avs_writedata[CMD_HOME_BIT];
			cmd_home_q <= avs_write && !wait_q && word_addr == REG_COMMAND && state_q == SH_IDLE
				&& avs_writedata[CMD_HOME_BIT];
			if (avs_write && !wait_q && word_addr == REG_COMMAND) begin
				cmd_ccw_q <= avs_writedata[CMD_CCW_BIT];
			end
		end
	end

	// motion sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= SH_IDLE;
			homing_q <= 1'b0;
			ccw_phase_q <= 1'b0;
			dir_q <= 1'b0;
			homed_q <= 1'b0;
			abort_q <= 1'b0;
			idx_q <= 8'h00;
			acc_q <= 8'h00;
			rem_q <= 32'h00000000;
			up_steps_q <= 32'h00000000;
			period_q <= 24'h000000;
			elap_q <= 24'h000000;
		end else begin
			case (state_q)
				SH_IDLE: begin
					elap_q <= 24'h000000;
					if (cmd_move_q || cmd_home_q) begin
						homed_q <= 1'b0;
						homing_q <= cmd_home_q;
						// initial compare picks the first phase
						ccw_phase_q <= cmd_home_q && match;
						dir_q <= cmd_home_q ? match : cmd_ccw_q;
						idx_q <= start_idx_q;
						acc_q <= 8'h00;
						up_steps_q <= 32'h00000000;
						rem_q <= steps_q;
						period_q <= cmd_home_q ? home_period : 24'(rate_mem[start_idx_q]);
						// limit already low: no step at all
						abort_q <= start_lim;
						if (!start_lim && (cmd_home_q || steps_q != 32'h00000000)) begin
							state_q <= SH_STEP;
						end
					end
				end
				SH_STEP: begin
					// limit mid-step: abandon at once, no ramp down
					if (lim_hit) begin
						abort_q <= 1'b1;
						homing_q <= 1'b0;
						ccw_phase_q <= 1'b0;
						state_q <= SH_IDLE;
					end else if (elap_q + 24'h000002 >= period_q) begin // next state adds the last cycle
						elap_q <= 24'h000000;
						if (!homing_q) begin
							rem_q <= rem_q - 32'h00000001;
						end
						// display after each home step when enabled
						state_q <= (homing_q && mode_q[MODE_DISP_BIT]) ? SH_DISP : SH_NEXT;
					end else begin
						elap_q <= elap_q + 24'h000001;
					end
				end
				SH_DISP: begin
					// next step waits for the whole string
					if (disp_valid_q && disp_ready && char_q == 4'(DISP_CHARS - 1)) begin
						state_q <= SH_NEXT;
					end
				end
				SH_NEXT: begin
					if (homing_q) begin
						if (ccw_phase_q && !match) begin
							// left the match, turn to cw
							ccw_phase_q <= 1'b0;
							dir_q <= 1'b0;
							state_q <= SH_STEP;
						end else if (home_hit) begin
							// matched on a cw step: done, back to idle
							homed_q <= 1'b1;
							homing_q <= 1'b0;
							state_q <= SH_IDLE;
						end else begin
							state_q <= SH_STEP;
						end
					end else if (rem_q == 32'h00000000) begin
						state_q <= SH_IDLE;
					end else begin
						acc_q <= acc_sum[7:0];
						// climb while more steps remain than were spent climbing
						if (rem_q > up_steps_q) begin
							if (idx_q < top_idx) begin
								up_steps_q <= up_steps_q + 32'h00000001;
								if (acc_sum[8]) begin
									idx_q <= idx_q + 8'h01;
								end
							end
						end else if (acc_sum[8] && idx_q > start_idx_q) begin
							// descent uses the same slope steps as the climb
							idx_q <= idx_q - 8'h01;
						end
						// last step always back at the start rate
						if (rem_q == 32'h00000001) begin
							idx_q <= start_idx_q;
						end
						state_q <= SH_STEP;
					end
				end
				default: begin
					state_q <= SH_IDLE;
				end
			endcase
			// period of the coming step follows the index just chosen
			if (state_q == SH_STEP && elap_q == 24'h000000) begin
				period_q <= homing_q ? home_period : run_period;
			end
		end
	end

	// step pulse at the head of each step period
	always_ff @(posedge clk) begin
		if (rst) begin
			pulse_q <= 1'b0;
		end else begin
			pulse_q <= (state_q == SH_STEP) && !lim_hit && (elap_q < 24'(PULSE_CYC));
		end
	end

	// position: counts on each step, cw up; zeroed only on a home match
	always_ff @(posedge clk) begin
		if (rst) begin
			pos_q <= 32'h00000000;
		end else if (home_hit) begin
			pos_q <= 32'h00000000;
		end else if (step_start && !lim_hit) begin
			pos_q <= dir_q ? pos_q - 32'h00000001 : pos_q + 32'h00000001;
		end
	end

	// hex digit helper for the display string
	function automatic logic [7:0] hex_char(input logic [3:0] nib);
		hex_char = (nib < 4'hA) ? 8'h30 + {4'h0, nib} : 8'h37 + {4'h0, nib};
	endfunction

	// position string: space, eight hex digits, cr, lf
	always_ff @(posedge clk) begin
		if (rst) begin
			char_q <= 4'h0;
			disp_valid_q <= 1'b0;
			disp_data_q <= 8'h00;
		end else if (state_q == SH_DISP) begin
			if (!disp_valid_q) begin
				disp_valid_q <= 1'b1;
				disp_data_q <= CH_SPACE;
				char_q <= 4'h0;
			end else if (disp_ready) begin
				if (char_q == 4'(DISP_CHARS - 1)) begin
					disp_valid_q <= 1'b0;
				end else begin
					char_q <= char_q + 4'h1;
					if (char_q < 4'h8) begin
						disp_data_q <= hex_char(pos_q[31 - 4 * char_q -: 4]);
					end else begin
						disp_data_q <= (char_q == 4'h8) ? CH_CR : CH_LF;
					end
				end
			end
		end else begin
			disp_valid_q <= 1'b0;
			char_q <= 4'h0;
		end
	end

	// registered outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			rotation_direction <= 1'b0;
			busy <= 1'b0;
		end else begin
			rotation_direction <= dir_q;
			busy <= (state_q != SH_IDLE) || cmd_move_q || cmd_home_q;
		end
	end

	assign avs_readdata = readdata_q;
	assign avs_waitrequest = wait_q;
	assign step_pulse = pulse_q;
	assign disp_data = disp_data_q;
	assign disp_valid = disp_valid_q;
endmodule

// file: dv/shsrp_checker.sv
// shsrp_checker: port assertions for the home-seek and rate-profile block.
// assumes it is bound onto shsrp_top with the same pulse length.
`timescale 1ns/1ps
module shsrp_checker #(
	parameter int PULSE_CYC = 2
) (
	// clock, reset and bus handshake
	input wire logic clk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	// motor, limits, display
	input wire logic step_pulse,
	input wire logic rotation_direction,
	input wire logic clockwise_stop_input,
	input wire logic counterclockwise_stop_input,
	input wire logic [7:0] disp_data,
	input wire logic disp_valid,
	input wire logic disp_ready,
	input wire logic busy
);
	logic [7:0] pw_q;

	// length of the current pulse; a limit stop may cut it short
	always_ff @(posedge clk) begin
		if (rst || !step_pulse)
			pw_q <= 8'h00;
		else
			pw_q <= pw_q + 8'h01;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	clockwise_stop_input_a: assert property ((!rotation_direction && !clockwise_stop_input) [*4] |-> !step_pulse)
		else $error("cw step into limit");
	counterclockwise_stop_input_a: assert property ((rotation_direction && !counterclockwise_stop_input) [*4] |-> !step_pulse)
		else $error("ccw step into limit");
	disp_wait_a: assert property (disp_valid |-> !$rose(step_pulse))
		else $error("step during display");
	disp_hold_a: assert property (disp_valid && !disp_ready |=> disp_valid && $stable(disp_data))
		else $error("display char dropped");
	step_busy_a: assert property ($rose(step_pulse) |-> busy)
		else $error("step while idle");
	pulse_width_a: assert property ($fell(step_pulse) && clockwise_stop_input && counterclockwise_stop_input
		|-> pw_q == PULSE_CYC)
		else $error("pulse width wrong");
	idle_quiet_a: assert property ($fell(busy) |=> !step_pulse [*4])
		else $error("step after end");

	cover property ($rose(step_pulse) && rotation_direction);
	cover property (disp_valid && disp_ready);
	cover property ($fell(busy) && !clockwise_stop_input);
endmodule

// file: dv/shsrp_motor_model.sv
// shsrp_motor_model: motor driver with home sensor and end limits.
// assumes one step per rising step pulse; limits are active low.
`timescale 1ns/1ps
module shsrp_motor_model (
	// driver side
	input wire logic clk,
	input wire logic step_pulse,
	input wire logic rotation_direction,
	// sensor placement set by the bench
	input int home_at,
	input int cw_end,
	input int ccw_end,
	// sensors, limits and travel
	output logic [7:0] user_bits,
	output logic [7:0] data_bits,
	output logic clockwise_stop_input,
	output logic counterclockwise_stop_input,
	output int mech,
	output int ccw_n
);
	logic prev_q = 1'b0;

	initial begin
		mech = 0;
		ccw_n = 0;
	end

	// direction level sense
	// level taken at the pulse head, low is clockwise
	always @(posedge clk) begin
		prev_q <= step_pulse;
		if (step_pulse && !prev_q) begin
			mech <= rotation_direction ? mech - 1 : mech + 1;
			ccw_n <= ccw_n + int'(rotation_direction);
		end
	end

	// home sensor flag
	// data bus carries the inverse so a test-for-0 finds the same edge
	assign user_bits = {7'h00, mech >= home_at};
	assign data_bits = ~user_bits;
	assign clockwise_stop_input = !(mech >= cw_end);
	assign counterclockwise_stop_input = !(mech <= ccw_end);
endmodule

// file: dv/shsrp_top_tb_top.sv
// shsrp_top_tb_top: directed bench for the home-seek and rate-profile block.
// assumes the motor model beside it; table entry i holds a period of 300-i.
`timescale 1ns/1ps
module shsrp_top_tb_top;
	import shsrp_pkg::*;
	localparam int PCYC = 2;
	localparam int TMAX = 40000;
	logic clk;
	logic rst = 1'b1;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic disp_ready = 1'b0;
	logic pulse_d = 1'b0;
	logic [11:0] avs_address = 12'h000;
	logic [31:0] avs_writedata = 32'h0;
	logic avs_waitrequest, step_pulse, rotation_direction, disp_valid, busy;
	logic clockwise_stop_input, counterclockwise_stop_input;
	logic [7:0] user_bits, data_bits, disp_data;
	logic [31:0] avs_readdata, rd;
	logic [7:0] chars[$];
	int home_at = 6, cw_end = 1000, ccw_end = -1000, mech, ccw_n;
	int num_errors = 0, cmp_count = 0, cyc = 0, gap = 0, n_rise = 0, first_per = 0, min_per = 0;

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	shsrp_top #(.PULSE_CYC(PCYC)) u_shsrp_top (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .step_pulse(step_pulse), .rotation_direction(rotation_direction),
		.clockwise_stop_input(clockwise_stop_input), .counterclockwise_stop_input(counterclockwise_stop_input),
		.user_bits(user_bits), .data_bits(data_bits), .disp_data(disp_data), .disp_valid(disp_valid),
		.disp_ready(disp_ready), .busy(busy));

	shsrp_motor_model u_shsrp_motor_model (.clk(clk), .step_pulse(step_pulse),
		.rotation_direction(rotation_direction), .home_at(home_at), .cw_end(cw_end), .ccw_end(ccw_end),
		.user_bits(user_bits), .data_bits(data_bits), .clockwise_stop_input(clockwise_stop_input),
		.counterclockwise_stop_input(counterclockwise_stop_input), .mech(mech), .ccw_n(ccw_n));

	// step spacing, display capture with a stalling sink, and the hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		gap <= gap + 1;
		pulse_d <= step_pulse;
		disp_ready <= ~disp_ready;
		if (step_pulse && !pulse_d) begin
			n_rise <= n_rise + 1;
			gap <= 1;
			if (n_rise == 1) first_per <= gap;
			if (n_rise >= 1 && gap < min_per) min_per <= gap;
		end
		if (disp_valid && disp_ready) chars.push_back(disp_data);
		if (cyc == TMAX) begin
			num_errors++;
			tally_and_finish();
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %0h seen %0h", nm, exp, got);
		end
	endtask

	// one bus access; held until waitrequest is seen low, then one idle edge
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		if (n == 20) chk("bus wait", 32'h0, 32'h1);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask

	// issue a command, wait for the motion to end, then check the outcome
	task automatic run(input logic [31:0] cmd, input int pos, input int m, input logic hm, input logic ab);
		int n;
		n = 0;
		n_rise = 0;
		min_per = 32'h7FFF_FFFF;
		chars.delete();
		bus(1'b1, REG_COMMAND, cmd);
		do begin
			@(posedge clk);
			n++;
		end while (busy !== 1'b0 && n < 20000);
		chk("busy", 32'h0, {31'h0, busy});
		bus(1'b0, REG_POSITION, 32'h0);
		chk("position", pos, rd);
		chk("motor", m, mech);
		bus(1'b0, REG_STATUS, 32'h0);
		chk("homed", {31'h0, hm}, {31'h0, rd[ST_HOMED_BIT]});
		chk("abort", {31'h0, ab}, {31'h0, rd[ST_ABORT_BIT]});
	endtask

	task automatic tally_and_finish();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// falling periods, so a higher index steps faster
		for (int i = 0; i < RATE_ENTRIES; i++) begin
			bus(1'b1, REG_TABLE_BASE + 12'(4 * i), 32'(300 - i));
		end
		bus(1'b0, REG_TABLE_BASE + 12'h3FC, 32'h0);
		chk("table top", 32'h2D, rd);
		bus(1'b0, 12'h100, 32'h0);
		chk("unmapped", 32'h0, rd);
		bus(1'b1, REG_START_RATE, 32'hC8);
		bus(1'b1, REG_SLEW_RATE, 32'hCB);
		bus(1'b1, REG_SLOPE, 32'hFF);
		bus(1'b1, REG_STEPS, 32'h14);
		run(32'h1, 20, 20, 1'b0, 1'b0);
		chk("start period", 32'h64, first_per);
		chk("slew period", 32'h61, min_per);
		bus(1'b1, REG_SLOPE, 32'h1);
		run(32'h101, 0, 0, 1'b0, 1'b0);
		chk("slope one", 32'h64, min_per);
		bus(1'b1, REG_SLOPE, 32'hFF);
		bus(1'b1, REG_STEPS, 32'h4);
		run(32'h1, 4, 4, 1'b0, 1'b0);
		chk("short ramp", 32'h1, 32'(min_per > 97));
		// no match at start: clockwise only, test user bit 0 for 1
		bus(1'b1, REG_HOME_ARG, 32'h0);
		run(32'h2, 0, 6, 1'b1, 1'b0);
		chk("no ccw", 32'h14, ccw_n);
		chk("home period", 32'h7D0, first_per);
		// match at start: one ccw step off, one cw back, with display on
		bus(1'b1, REG_MODE, 32'h10);
		bus(1'b1, REG_HOME_ARG, 32'h18);
		run(32'h2, 0, 6, 1'b1, 1'b0);
		chk("ccw phase", 32'h15, ccw_n);
		chk("chars", 32'h16, chars.size());
		chk("ccw digit", 32'h46, chars[1]);
		chk("home digit", 32'h30, chars[19]);
		chk("stretch", 32'h1, 32'(first_per > 2000));
		// group match never met; the clockwise_stop_input ends the seek
		bus(1'b1, REG_MODE, 32'h0);
		bus(1'b1, REG_HOME_ARG, 32'h7F);
		cw_end = 8;
		run(32'h2, 2, 8, 1'b0, 1'b1);
		bus(1'b1, REG_STEPS, 32'h5);
		run(32'h1, 2, 8, 1'b0, 1'b1);
		ccw_end = 5;
		run(32'h101, -1, 5, 1'b0, 1'b1);
		// group pattern on user bits 0-5 met one cw step further on
		bus(1'b1, REG_HOME_ARG, 32'h41);
		run(32'h2, 0, 6, 1'b1, 1'b0);
		// a zero slope is kept as the slowest setting
		bus(1'b1, REG_SLOPE, 32'h0);
		bus(1'b0, REG_SLOPE, 32'h0);
		chk("slope floor", 32'h1, rd);
		tally_and_finish();
	end
endmodule

bind shsrp_top shsrp_checker #(.PULSE_CYC(PULSE_CYC)) u_shsrp_checker (.clk(clk), .rst(rst),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .step_pulse(step_pulse),
	.rotation_direction(rotation_direction), .clockwise_stop_input(clockwise_stop_input),
	.counterclockwise_stop_input(counterclockwise_stop_input), .disp_data(disp_data),
	.disp_valid(disp_valid), .disp_ready(disp_ready), .busy(busy));
